// ===== ttc_consts.svh
// Timer unit constants: word indices, field positions, reset values, phase timing.
// Assumes 32-bit classic Wishbone, byte address = 4 * word index.
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH

`define TTC_IDX_MODE 6'h00
`define TTC_IDX_CTRL 6'h01
`define TTC_IDX_LOW0 6'h02
`define TTC_IDX_HIGH0 6'h03
`define TTC_IDX_LOW1 6'h04
`define TTC_IDX_HIGH1 6'h05
`define TTC_IDX_CTRL2 6'h06
`define TTC_IDX_CNT2L 6'h07
`define TTC_IDX_CNT2H 6'h08
`define TTC_IDX_CAPL 6'h09
`define TTC_IDX_CAPH 6'h0a
`define TTC_IDX_CFG 6'h0b

`define TTC_MODE_GATE1 7
`define TTC_MODE_CT1 6
`define TTC_MODE_SEL1_HI 5
`define TTC_MODE_SEL1_LO 4
`define TTC_MODE_GATE0 3
`define TTC_MODE_CT0 2
`define TTC_MODE_SEL0_HI 1
`define TTC_MODE_SEL0_LO 0

`define TTC_CTRL_OVF1 7
`define TTC_CTRL_RUN1 6
`define TTC_CTRL_OVF0 5
`define TTC_CTRL_RUN0 4

`define TTC_CTRL2_OVF 7
`define TTC_CTRL2_EXF 6
`define TTC_CTRL2_RXBAUD 5
`define TTC_CTRL2_TXBAUD 4
`define TTC_CTRL2_EXEN 3
`define TTC_CTRL2_RUN 2
`define TTC_CTRL2_SRC 1
`define TTC_CTRL2_CAP 0

`define TTC_CFG_SIX_CLOCK 0

`define TTC_RESET_BYTE 8'h00

`define TTC_CLOCKS_12T 4'hc
`define TTC_CLOCKS_6T 4'h6
`define TTC_PHASE_C3 4'h2
`define TTC_PHASE_C4 4'h3

`endif

// ===== ttc_pkg.sv
// Types of the timer unit.
// Enum values are implicit; nothing comes from ttc_consts.svh.
package ttc_pkg;

    typedef enum logic [1:0] {
        TTC_MODE_13BIT,
        TTC_MODE_16BIT,
        TTC_MODE_AUTO8,
        TTC_MODE_SPLIT
    } ttc_mode_e;

    typedef struct packed {
        logic trig_pin;
        logic third_count_pin;
        logic count_input_pin_one;
        logic count_input_pin_zero;
    } ttc_pins_s;

endpackage

// ===== ttc_top.sv
// Timer unit: two 13/16/8-bit counters with split mode, one 16-bit capture/reload counter.
// Assumes classic Wishbone, pins synchronous to sys_clk_i, vector pulses from interrupt logic.
//
// Summary of operation
// - A machine cycle lasts 12 or 6 clocks, chosen by the configuration bit.
// - Count pins are sampled once per machine cycle; high then low counts once.
// - Edge detection spans two machine cycles, limiting count rate to clock/24, or clock/12 with 6-clock cycles.
// - Counts update at phase C3; an edge lands one machine cycle after detection.
// - Mode register bit 2 and bit 6 pick counter function; two bits pick mode.
// - Timer function counts once per machine cycle, clock/12 by default.
// - Mode 0 counts 13 bits: high byte and five low bits of low byte.
// - Counters 0 and 1 run when run bit set and gate clear or pin high.
// - Mode 0 wrap from 1fff to 0000 sets the overflow flag.
// - Mode 1 wrap from ffff to 0000 sets the overflow flag.
// - Mode 2 low byte wraps from ff, sets flag, reloads from high byte.
// - Mode 3 on counter 1 freezes its count.
// - Counter 0 mode 3 splits it; high byte uses counter 1 run bit and flag.
// - Then counter 1 ignores its run bit and flag but keeps gating and baud output.
// - Counter 2 counts pin edges or machine cycles, gated by its run bit.
// - Capture mode counts up 16 bits; rollover sets counter 2 overflow flag.
// - Capture mode trigger edge copies count to capture pair and sets trigger flag.
// - Reload mode rollover from ffff reloads from capture pair and sets overflow flag.
// - Reload mode trigger edge also reloads and sets trigger flag.
// - Baud select bits make rollover reload without setting the overflow flag.
// - Baud mode trigger edge sets the trigger flag.
// - Counter 0 and 1 overflow flags clear on interrupt vector acknowledge.
// - Counter 2 flags clear only by software writes.
`include "ttc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ttc_top import ttc_pkg::*; (
    input wire logic sys_clk_i, // System clock, 10 MHz.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [7:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire ttc_pins_s count_pins_i, // External count and trigger pins.
    input wire logic ext_interrupt_pin_zero_i, // Gate pin for counter 0.
    input wire logic ext_interrupt_pin_one_i, // Gate pin for counter 1.
    input wire logic vector_ack_zero_i, // Counter 0 service entry pulse.
    input wire logic vector_ack_one_i, // Counter 1 service entry pulse.
    output logic overflow_flag_zero_o, // Counter 0 overflow flag.
    output logic overflow_flag_one_o, // Counter 1 overflow flag.
    output logic third_overflow_flag_o, // Counter 2 overflow flag.
    output logic ext_trigger_flag_o, // Counter 2 external trigger flag.
    output logic baud_tick_one_o, // Pulse on counter 1 rollover.
    output logic baud_tick_two_o // Pulse on counter 2 rollover in baud mode.
);

    logic [7:0] timer_mode_reg, timer_mode_next;
    logic [7:0] timer_control_reg, timer_control_next;
    logic [7:0] low_byte_zero_reg, low_byte_zero_next;
    logic [7:0] high_byte_zero_reg, high_byte_zero_next;
    logic [7:0] low_byte_one_reg, low_byte_one_next;
    logic [7:0] high_byte_one_reg, high_byte_one_next;
    logic [7:0] third_timer_control_reg, third_timer_control_next;
    logic [15:0] third_count_reg, third_count_next;
    logic [15:0] capture_reload_reg, capture_reload_next;
    logic config_six_reg, config_six_next;
    logic [3:0] phase_reg, phase_next;
    logic [3:0] sample_prev_reg, sample_cur_reg, edge_pend_reg;
    logic [3:0] sample_prev_next, sample_cur_next, edge_pend_next;
    logic ack_reg;
    logic [31:0] dat_reg, dat_next;
    logic tick_one_reg, tick_one_next, tick_two_reg, tick_two_next;

    // Machine cycle pacing.
    wire [3:0] phase_last = (config_six_reg ? `TTC_CLOCKS_6T : `TTC_CLOCKS_12T) - 4'h1;
    wire update_tick = (phase_reg == `TTC_PHASE_C3);
    wire sample_tick = (phase_reg == `TTC_PHASE_C4);
    wire [3:0] pins_now = count_pins_i;

    // Bus decode.
    wire [5:0] word_idx = wb_adr_i[7:2];
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_wr = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
    wire [7:0] wdata = wb_dat_i[7:0];
    wire wr_mode = bus_wr & (word_idx == `TTC_IDX_MODE);
    wire wr_ctrl = bus_wr & (word_idx == `TTC_IDX_CTRL);
    wire wr_low0 = bus_wr & (word_idx == `TTC_IDX_LOW0);
    wire wr_high0 = bus_wr & (word_idx == `TTC_IDX_HIGH0);
    wire wr_low1 = bus_wr & (word_idx == `TTC_IDX_LOW1);
    wire wr_high1 = bus_wr & (word_idx == `TTC_IDX_HIGH1);
    wire wr_ctrl2 = bus_wr & (word_idx == `TTC_IDX_CTRL2);
    wire wr_cnt2l = bus_wr & (word_idx == `TTC_IDX_CNT2L);
    wire wr_cnt2h = bus_wr & (word_idx == `TTC_IDX_CNT2H);
    wire wr_capl = bus_wr & (word_idx == `TTC_IDX_CAPL);
    wire wr_caph = bus_wr & (word_idx == `TTC_IDX_CAPH);
    wire wr_cfg = bus_wr & (word_idx == `TTC_IDX_CFG);

    // Mode register fields.
    wire [1:0] mode0_bits = timer_mode_reg[`TTC_MODE_SEL0_HI:`TTC_MODE_SEL0_LO];
    wire [1:0] mode1_bits = timer_mode_reg[`TTC_MODE_SEL1_HI:`TTC_MODE_SEL1_LO];
    wire ttc_mode_e mode0 = ttc_mode_e'(mode0_bits);
    wire ttc_mode_e mode1 = ttc_mode_e'(mode1_bits);
    wire counter_fn0 = timer_mode_reg[`TTC_MODE_CT0];
    wire counter_fn1 = timer_mode_reg[`TTC_MODE_CT1];
    wire run0 = timer_control_reg[`TTC_CTRL_RUN0];
    wire run1 = timer_control_reg[`TTC_CTRL_RUN1];
    wire split0 = (mode0 == TTC_MODE_SPLIT);

    // Count enables, taken at the update phase.
    wire gate_ok0 = ~timer_mode_reg[`TTC_MODE_GATE0] | ext_interrupt_pin_zero_i;
    wire gate_ok1 = ~timer_mode_reg[`TTC_MODE_GATE1] | ext_interrupt_pin_one_i;
    wire src0 = counter_fn0 ? edge_pend_reg[0] : 1'b1;
    wire src1 = counter_fn1 ? edge_pend_reg[1] : 1'b1;
    wire inc0 = update_tick & run0 & gate_ok0 & src0;
    wire run1_eff = split0 ? 1'b1 : run1;
    wire inc1 = update_tick & run1_eff & gate_ok1 & src1 & (mode1 != TTC_MODE_SPLIT);
    wire inc0_high = update_tick & split0 & run1;

    // Counter 0 and 1 arithmetic.
    wire [12:0] c0_13 = {high_byte_zero_reg, low_byte_zero_reg[4:0]} + 13'h0001;
    wire [15:0] c0_16 = {high_byte_zero_reg, low_byte_zero_reg} + 16'h0001;
    wire [12:0] c1_13 = {high_byte_one_reg, low_byte_one_reg[4:0]} + 13'h0001;
    wire [15:0] c1_16 = {high_byte_one_reg, low_byte_one_reg} + 16'h0001;
    wire [7:0] lo0_inc = low_byte_zero_reg + 8'h01;
    wire [7:0] hi0_inc = high_byte_zero_reg + 8'h01;
    wire [7:0] lo1_inc = low_byte_one_reg + 8'h01;
    wire all13_0 = &{high_byte_zero_reg, low_byte_zero_reg[4:0]};
    wire all16_0 = &{high_byte_zero_reg, low_byte_zero_reg};
    wire all13_1 = &{high_byte_one_reg, low_byte_one_reg[4:0]};
    wire all16_1 = &{high_byte_one_reg, low_byte_one_reg};
    wire lo0_full = &low_byte_zero_reg;
    wire hi0_full = &high_byte_zero_reg;
    wire lo1_full = &low_byte_one_reg;

    // Counter 2 controls.
    wire run2 = third_timer_control_reg[`TTC_CTRL2_RUN];
    wire src2 = third_timer_control_reg[`TTC_CTRL2_SRC] ? edge_pend_reg[2] : 1'b1;
    wire inc2 = update_tick & run2 & src2;
    wire baud_mode = third_timer_control_reg[`TTC_CTRL2_RXBAUD] | third_timer_control_reg[`TTC_CTRL2_TXBAUD];
    wire capture_mode = third_timer_control_reg[`TTC_CTRL2_CAP] & ~baud_mode;
    wire trig2 = update_tick & third_timer_control_reg[`TTC_CTRL2_EXEN] & edge_pend_reg[3];
    wire roll2 = inc2 & (&third_count_reg);
    wire [15:0] cnt2_inc = third_count_reg + 16'h0001;

    // Pins are sampled at C4; an edge is held until the next C3.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            always_comb begin
                sample_cur_next[gi] = sample_tick ? pins_now[gi] : sample_cur_reg[gi];
                sample_prev_next[gi] = sample_tick ? sample_cur_reg[gi] : sample_prev_reg[gi];
                if (sample_tick) begin
                    edge_pend_next[gi] = sample_cur_reg[gi] & ~pins_now[gi];
                end else if (update_tick) begin
                    edge_pend_next[gi] = 1'b0;
                end else begin
                    edge_pend_next[gi] = edge_pend_reg[gi];
                end
            end
        end
    endgenerate

    // Counters 0 and 1, then their flags.
    logic set_ovf0, set_ovf1, roll1;
    always_comb begin
        low_byte_zero_next = low_byte_zero_reg;
        high_byte_zero_next = high_byte_zero_reg;
        low_byte_one_next = low_byte_one_reg;
        high_byte_one_next = high_byte_one_reg;
        set_ovf0 = 1'b0;
        set_ovf1 = 1'b0;
        roll1 = 1'b0;
        if (inc0) begin
            unique case (mode0)
                TTC_MODE_13BIT: begin
                    {high_byte_zero_next, low_byte_zero_next[4:0]} = c0_13;
                    set_ovf0 = all13_0;
                end
                TTC_MODE_16BIT: begin
                    {high_byte_zero_next, low_byte_zero_next} = c0_16;
                    set_ovf0 = all16_0;
                end
                TTC_MODE_AUTO8: begin
                    low_byte_zero_next = lo0_full ? high_byte_zero_reg : lo0_inc;
                    set_ovf0 = lo0_full;
                end
                TTC_MODE_SPLIT: begin
                    low_byte_zero_next = lo0_inc;
                    set_ovf0 = lo0_full;
                end
            endcase
        end
        if (inc0_high) begin
            high_byte_zero_next = hi0_inc;
            set_ovf1 = hi0_full;
        end
        if (inc1) begin
            unique case (mode1)
                TTC_MODE_13BIT: begin
                    {high_byte_one_next, low_byte_one_next[4:0]} = c1_13;
                    roll1 = all13_1;
                end
                TTC_MODE_16BIT: begin
                    {high_byte_one_next, low_byte_one_next} = c1_16;
                    roll1 = all16_1;
                end
                TTC_MODE_AUTO8: begin
                    low_byte_one_next = lo1_full ? high_byte_one_reg : lo1_inc;
                    roll1 = lo1_full;
                end
                TTC_MODE_SPLIT: begin
                    roll1 = 1'b0;
                end
            endcase
        end
        if (roll1 & ~split0) begin
            set_ovf1 = 1'b1;
        end
        if (wr_low0) begin
            low_byte_zero_next = wdata;
        end
        if (wr_high0) begin
            high_byte_zero_next = wdata;
        end
        if (wr_low1) begin
            low_byte_one_next = wdata;
        end
        if (wr_high1) begin
            high_byte_one_next = wdata;
        end
        tick_one_next = roll1;
        timer_control_next = wr_ctrl ? {wdata[7:4], 4'h0} : timer_control_reg;
        if (vector_ack_zero_i) begin
            timer_control_next[`TTC_CTRL_OVF0] = 1'b0;
        end
        if (vector_ack_one_i) begin
            timer_control_next[`TTC_CTRL_OVF1] = 1'b0;
        end
        if (set_ovf0) begin
            timer_control_next[`TTC_CTRL_OVF0] = 1'b1;
        end
        if (set_ovf1) begin
            timer_control_next[`TTC_CTRL_OVF1] = 1'b1;
        end
    end

    // Counter 2 with capture, reload and baud modes.
    logic set_ovf2, set_exf;
    always_comb begin
        third_count_next = third_count_reg;
        capture_reload_next = capture_reload_reg;
        set_ovf2 = 1'b0;
        set_exf = trig2;
        tick_two_next = 1'b0;
        if (capture_mode) begin
            if (inc2) begin
                third_count_next = cnt2_inc;
                set_ovf2 = roll2;
            end
            if (trig2) begin
                capture_reload_next = third_count_reg;
            end
        end else begin
            if (roll2) begin
                third_count_next = capture_reload_reg;
                set_ovf2 = ~baud_mode;
                tick_two_next = baud_mode;
            end else if (inc2) begin
                third_count_next = cnt2_inc;
            end
            if (trig2 & ~baud_mode) begin
                third_count_next = capture_reload_reg;
            end
        end
        if (wr_cnt2l) begin
            third_count_next[7:0] = wdata;
        end
        if (wr_cnt2h) begin
            third_count_next[15:8] = wdata;
        end
        if (wr_capl) begin
            capture_reload_next[7:0] = wdata;
        end
        if (wr_caph) begin
            capture_reload_next[15:8] = wdata;
        end
        third_timer_control_next = wr_ctrl2 ? wdata : third_timer_control_reg;
        if (set_ovf2) begin
            third_timer_control_next[`TTC_CTRL2_OVF] = 1'b1;
        end
        if (set_exf) begin
            third_timer_control_next[`TTC_CTRL2_EXF] = 1'b1;
        end
    end

    // Read mux and remaining next values.
    logic [7:0] rd_byte;
    always_comb begin
        unique case (word_idx)
            `TTC_IDX_MODE: rd_byte = timer_mode_reg;
            `TTC_IDX_CTRL: rd_byte = timer_control_reg;
            `TTC_IDX_LOW0: rd_byte = low_byte_zero_reg;
            `TTC_IDX_HIGH0: rd_byte = high_byte_zero_reg;
            `TTC_IDX_LOW1: rd_byte = low_byte_one_reg;
            `TTC_IDX_HIGH1: rd_byte = high_byte_one_reg;
            `TTC_IDX_CTRL2: rd_byte = third_timer_control_reg;
            `TTC_IDX_CNT2L: rd_byte = third_count_reg[7:0];
            `TTC_IDX_CNT2H: rd_byte = third_count_reg[15:8];
            `TTC_IDX_CAPL: rd_byte = capture_reload_reg[7:0];
            `TTC_IDX_CAPH: rd_byte = capture_reload_reg[15:8];
            `TTC_IDX_CFG: rd_byte = {7'h00, config_six_reg};
            default: rd_byte = 8'h00;
        endcase
        dat_next = (bus_req & ~ack_reg) ? {24'h000000, rd_byte} : dat_reg;
        timer_mode_next = wr_mode ? wdata : timer_mode_reg;
        config_six_next = wr_cfg ? wdata[`TTC_CFG_SIX_CLOCK] : config_six_reg;
        phase_next = (phase_reg >= phase_last) ? 4'h0 : phase_reg + 4'h1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            timer_mode_reg <= `TTC_RESET_BYTE;
            timer_control_reg <= `TTC_RESET_BYTE;
            low_byte_zero_reg <= `TTC_RESET_BYTE;
            high_byte_zero_reg <= `TTC_RESET_BYTE;
            low_byte_one_reg <= `TTC_RESET_BYTE;
            high_byte_one_reg <= `TTC_RESET_BYTE;
            third_timer_control_reg <= `TTC_RESET_BYTE;
            third_count_reg <= 16'h0000;
            capture_reload_reg <= 16'h0000;
            config_six_reg <= 1'b0;
            phase_reg <= 4'h0;
        end else begin
            timer_mode_reg <= timer_mode_next;
            timer_control_reg <= timer_control_next;
            low_byte_zero_reg <= low_byte_zero_next;
            high_byte_zero_reg <= high_byte_zero_next;
            low_byte_one_reg <= low_byte_one_next;
            high_byte_one_reg <= high_byte_one_next;
            third_timer_control_reg <= third_timer_control_next;
            third_count_reg <= third_count_next;
            capture_reload_reg <= capture_reload_next;
            config_six_reg <= config_six_next;
            phase_reg <= phase_next;
        end
    end

    // Pin samples reset high, so no false edge follows release while the pins are high; a pin low at release gives one edge.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            sample_prev_reg <= 4'hf;
            sample_cur_reg <= 4'hf;
            edge_pend_reg <= 4'h0;
        end else begin
            sample_prev_reg <= sample_prev_next;
            sample_cur_reg <= sample_cur_next;
            edge_pend_reg <= edge_pend_next;
        end
    end

    // Ack comes one cycle after a request and drops the cycle after.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            tick_one_reg <= 1'b0;
            tick_two_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            dat_reg <= dat_next;
            tick_one_reg <= tick_one_next;
            tick_two_reg <= tick_two_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign overflow_flag_zero_o = timer_control_reg[`TTC_CTRL_OVF0];
    assign overflow_flag_one_o = timer_control_reg[`TTC_CTRL_OVF1];
    assign third_overflow_flag_o = third_timer_control_reg[`TTC_CTRL2_OVF];
    assign ext_trigger_flag_o = third_timer_control_reg[`TTC_CTRL2_EXF];
    assign baud_tick_one_o = tick_one_reg;
    assign baud_tick_two_o = tick_two_reg;

endmodule // ttc_top

`default_nettype wire

// ===== ttc_top_properties.sv
// Checker: bus answer, flag clearing, tick spacing.
// Bound into ttc_top; one clock domain.
`include "ttc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ttc_top_properties (
    input wire logic sys_clk_i, // Clock.
    input wire logic resetn_i, // Reset.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic wb_we_i, // Write.
    input wire logic [7:0] wb_adr_i, // Address.
    input wire logic [31:0] wb_dat_o, // Read data.
    input wire logic wb_ack_o, // Answer.
    input wire logic vector_ack_zero_i, // Vector 0.
    input wire logic vector_ack_one_i, // Vector 1.
    input wire logic overflow_flag_zero_o, // Flag 0.
    input wire logic overflow_flag_one_o, // Flag 1.
    input wire logic third_overflow_flag_o, // Flag 2.
    input wire logic ext_trigger_flag_o, // Trigger flag.
    input wire logic baud_tick_one_o, // Tick 1.
    input wire logic baud_tick_two_o // Tick 2.
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    wire [5:0] idx = wb_adr_i[7:2];
    chk_ack_in_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read upper bits");
    chk_flag0_cause: assert property ($fell(overflow_flag_zero_o) |->
        $past(vector_ack_zero_i || wb_ack_o && wb_we_i && idx == `TTC_IDX_CTRL)) else $error("flag 0 fell");
    chk_flag1_cause: assert property ($fell(overflow_flag_one_o) |->
        $past(vector_ack_one_i || wb_ack_o && wb_we_i && idx == `TTC_IDX_CTRL)) else $error("flag 1 fell");
    chk_flag2_soft: assert property ($fell(third_overflow_flag_o) |->
        $past(wb_ack_o && wb_we_i && idx == `TTC_IDX_CTRL2)) else $error("flag 2 fell");
    chk_trig_soft: assert property ($fell(ext_trigger_flag_o) |->
        $past(wb_ack_o && wb_we_i && idx == `TTC_IDX_CTRL2)) else $error("trigger flag fell");
    chk_tick1_gap: assert property (baud_tick_one_o |=> !baud_tick_one_o [*5]) else $error("tick 1 gap");
    chk_tick2_gap: assert property (baud_tick_two_o |=> !baud_tick_two_o [*5]) else $error("tick 2 gap");
endmodule // ttc_top_properties
bind ttc_top ttc_top_properties u_ttc_top_properties (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .vector_ack_zero_i(vector_ack_zero_i), .vector_ack_one_i(vector_ack_one_i),
    .overflow_flag_zero_o(overflow_flag_zero_o), .overflow_flag_one_o(overflow_flag_one_o),
    .third_overflow_flag_o(third_overflow_flag_o), .ext_trigger_flag_o(ext_trigger_flag_o),
    .baud_tick_one_o(baud_tick_one_o), .baud_tick_two_o(baud_tick_two_o));
`default_nettype wire

// ===== ttc_pin_model.sv
// Far-side pins: toggles chosen count and trigger pins.
// Bench picks pins and half period; pins rest high.
`timescale 1ns/1ps
`default_nettype none
module ttc_pin_model import ttc_pkg::*; (
    input wire logic clk_i, // Clock.
    input wire logic resetn_i, // Reset, active low.
    input wire logic [3:0] en_i, // Pins that toggle.
    input wire logic [7:0] half_i, // Clocks per level.
    output ttc_pins_s pins_o // Pin levels.
);
    logic [7:0] cnt_reg;
    // Shorter levels could slip between machine-cycle samples.
    wire [7:0] lim = (half_i < 8'h0c) ? 8'h0b : half_i - 8'h01;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_reg <= 8'h00;
            pins_o <= 4'hf;
        end else if (cnt_reg >= lim) begin
            cnt_reg <= 8'h00;
            pins_o <= pins_o ^ en_i;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule // ttc_pin_model
`default_nettype wire

// ===== triple_timer_counter_unit_tb.sv
// Bench: registers, three counters and flags.
// Assumes design, pin model and checker compiled first.
`include "ttc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module triple_timer_counter_unit_tb;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, we = 1'b0, va0 = 1'b0, va1 = 1'b0, g0 = 1'b0, g1 = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] en = 4'h0;
    logic [7:0] hp = 8'h0c;
    logic [31:0] rdat;
    logic ack;
    logic [5:0] fl;
    logic [7:0] q, r1, r2;
    ttc_pkg::ttc_pins_s pins;
    int err_total = 0, n_tests = 0, n;
    ttc_top u_ttc_top (.sys_clk_i(clk), .resetn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .count_pins_i(pins),
        .ext_interrupt_pin_zero_i(g0), .ext_interrupt_pin_one_i(g1), .vector_ack_zero_i(va0),
        .vector_ack_one_i(va1), .overflow_flag_zero_o(fl[0]), .overflow_flag_one_o(fl[1]),
        .third_overflow_flag_o(fl[2]), .ext_trigger_flag_o(fl[3]), .baud_tick_one_o(fl[4]),
        .baud_tick_two_o(fl[5]));
    ttc_pin_model u_ttc_pin_model (.clk_i(clk), .resetn_i(rstn), .en_i(en), .half_i(hp), .pins_o(pins));
    initial forever #50 clk = ~clk;
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
        int k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        chk("bus ack", 8'h01, {7'h0, ack});
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e, input string nm);
        wb(1'b0, i, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic wt(input int b, input int lim, input string nm);
        int k = 0;
        while (fl[b] !== 1'b1 && k < lim) begin
            @(posedge clk);
            k++;
        end
        chk(nm, 8'h01, {7'h0, fl[b]});
    endtask
    task automatic vec(input logic one);
        @(posedge clk);
        {va1, va0} <= {one, !one};
        @(posedge clk);
        {va1, va0} <= 2'b00;
        @(posedge clk);
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        close_out;
    end
    initial begin
        void'($urandom(26415));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 12; i++) rd(i[5:0], 8'h00, "reset value");
        rd(6'h3f, 8'h00, "unmapped");
        r1 = 8'($urandom);
        wb(1'b1, `TTC_IDX_HIGH0, 8'hff);
        wb(1'b1, `TTC_IDX_LOW0, {r1[7:5], 5'h1f});
        wb(1'b1, `TTC_IDX_CTRL, 8'h10);
        wt(0, 40, "mode0 wrap");
        rd(`TTC_IDX_LOW0, {r1[7:5], 5'h00}, "mode0 low");
        rd(`TTC_IDX_HIGH0, 8'h00, "mode0 high");
        vec(1'b0);
        chk("vector clear", 8'h00, {7'h0, fl[0]});
        wb(1'b1, `TTC_IDX_MODE, 8'h0a);
        wb(1'b1, `TTC_IDX_HIGH0, r1);
        wb(1'b1, `TTC_IDX_LOW0, 8'hff);
        repeat (40) @(posedge clk);
        chk("gated", 8'h00, {7'h0, fl[0]});
        g0 <= 1'b1;
        wt(0, 40, "mode2 wrap");
        rd(`TTC_IDX_LOW0, r1, "reload low");
        rd(`TTC_IDX_HIGH0, r1, "reload high");
        wb(1'b1, `TTC_IDX_CTRL, 8'h00);
        $display("done counter 0");
        n = 1 + $urandom % 8;
        hp <= 8'(12 + $urandom % 9);
        wb(1'b1, `TTC_IDX_MODE, 8'h50);
        wb(1'b1, `TTC_IDX_HIGH1, 8'hff);
        wb(1'b1, `TTC_IDX_LOW1, 8'(256 - n));
        wb(1'b1, `TTC_IDX_CTRL, 8'h40);
        repeat (40) @(posedge clk);
        rd(`TTC_IDX_LOW1, 8'(256 - n), "no edges");
        en <= 4'h2;
        wt(1, 50 * n + 60, "edge wrap");
        chk("tick one", 8'h01, {7'h0, fl[4]});
        rd(`TTC_IDX_LOW1, 8'h00, "edge count");
        en <= 4'h0;
        vec(1'b1);
        chk("vector clear one", 8'h00, {7'h0, fl[1]});
        wb(1'b1, `TTC_IDX_LOW1, 8'h55);
        wb(1'b1, `TTC_IDX_HIGH0, 8'hff);
        wb(1'b1, `TTC_IDX_MODE, 8'h33);
        wt(1, 40, "split wrap");
        rd(`TTC_IDX_HIGH0, 8'h00, "split high");
        rd(`TTC_IDX_LOW1, 8'h55, "frozen");
        wb(1'b1, `TTC_IDX_CTRL, 8'h00);
        $display("done counter 1");
        r2 = 8'($urandom);
        wb(1'b1, `TTC_IDX_CNT2L, r1);
        wb(1'b1, `TTC_IDX_CNT2H, r2);
        wb(1'b1, `TTC_IDX_CTRL2, 8'h09);
        en <= 4'h8;
        wt(3, 100, "capture trigger");
        en <= 4'h0;
        rd(`TTC_IDX_CAPL, r1, "capture low");
        rd(`TTC_IDX_CAPH, r2, "capture high");
        vec(1'b0);
        chk("trigger kept", 8'h01, {7'h0, fl[3]});
        wb(1'b1, `TTC_IDX_CNT2L, 8'hff);
        wb(1'b1, `TTC_IDX_CNT2H, 8'hff);
        wb(1'b1, `TTC_IDX_CTRL2, 8'h04);
        wt(2, 40, "reload wrap");
        rd(`TTC_IDX_CNT2L, r1, "reload2 low");
        rd(`TTC_IDX_CNT2H, r2, "reload2 high");
        wb(1'b1, `TTC_IDX_CTRL2, 8'h00);
        rd(`TTC_IDX_CTRL2, 8'h00, "flags cleared");
        // All ones: baud mode rolls over every machine cycle.
        for (int i = 7; i < 11; i++) wb(1'b1, i[5:0], 8'hff);
        for (int c = 0; c < 2; c++) begin
            wb(1'b1, `TTC_IDX_CFG, 8'(c));
            wb(1'b1, `TTC_IDX_CTRL2, 8'h14);
            wt(5, 40, "baud tick");
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (fl[5] !== 1'b1 && n < 30);
            chk("machine cycle", (c == 1) ? 8'h06 : 8'h0c, 8'(n));
            chk("baud no flag", 8'h00, {7'h0, fl[2]});
        end
        $display("done counter 2");
        close_out;
    end
endmodule // triple_timer_counter_unit_tb
`default_nettype wire
